// >>> common/adct_pkg.sv
// Package: constants and types for the converter timing and trigger control
package adct_pkg;

  // Clock-select codes
  localparam logic [1:0] CKS_DIV32 = 2'h0;
  localparam logic [1:0] CKS_DIV16 = 2'h1;
  localparam logic [1:0] CKS_DIV8  = 2'h2;
  localparam logic [1:0] CKS_DIV4  = 2'h3;

  // Trigger source select codes
  localparam logic [1:0] TRG_PIN_OR_MFT = 2'h0;
  localparam logic [1:0] TRG_PIN_ONLY   = 2'h1;
  localparam logic [1:0] TRG_MFT_ONLY   = 2'h2;
  localparam logic [1:0] TRG_MOTOR_ONLY = 2'h3;

  // Timing in peripheral-clock states for setting 00
  localparam int unsigned PHASE_BITS     = 5;
  localparam int unsigned DELAY_MIN_00   = 31;
  localparam int unsigned DELAY_MAX_00   = 62;
  localparam int unsigned SAMPLE_00      = 256;
  localparam int unsigned CONV_MIN_00    = 1024;
  localparam int unsigned CONV_MAX_00    = 1055;
  localparam int unsigned SCAN_CONV_00   = 1024;
  // Minimum single conversion totals for the other settings
  localparam int unsigned CONV_MIN_01    = 515;
  localparam int unsigned CONV_MIN_10    = 259;
  localparam int unsigned CONV_MIN_11    = 131;
  // Start delay states outside the fixed count: flag pickup and sync tick
  localparam int unsigned DELAY_SYNC     = 2;
  // Counter width covers the longest conversion
  localparam int unsigned CNT_W          = 11;
  localparam int unsigned RES_W          = 10;

  typedef logic [CNT_W-1:0] adct_cnt_t;

  // Control bits grouped from the control and status registers
  typedef struct packed {
    logic       scan_mode;
    logic       scan_continuous;
    logic [1:0] scan_count_m1;
    logic [1:0] clock_select;
    logic [1:0] trigger_source_select;
    logic       end_irq_enable;
    logic       route_to_transfer_controller;
  } adct_ctrl_s;

  typedef struct packed {
    logic [1:0] mft_req;
    logic       motor_req;
    logic       ext_trigger_n;
  } adct_trig_s;

endpackage

// >>> hw/adct_phase_gen.sv
// Free-running clock-division phase and per-setting timing counts
module adct_phase_gen
  import adct_pkg::*;
#(
  parameter int unsigned P_BITS = PHASE_BITS
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic [1:0]  i_clock_select,
  output logic             o_phase_tick,
  output adct_cnt_t        o_sample_len,
  output adct_cnt_t        o_body_len,
  output adct_cnt_t        o_scan_len
);

  logic [P_BITS-1:0] phase_reg;
  logic [P_BITS-1:0] phase_next;
  logic [P_BITS-1:0] phase_mask;
  logic [2:0]        shift;
  int unsigned       conv_min;

  always_comb begin
    shift      = {1'b0, i_clock_select};
    phase_mask = P_BITS'({P_BITS{1'b1}} >> shift);
    phase_next = phase_reg + P_BITS'(1);
    case (i_clock_select)
      CKS_DIV32: conv_min = CONV_MIN_00;
      CKS_DIV16: conv_min = CONV_MIN_01;
      CKS_DIV8:  conv_min = CONV_MIN_10;
      CKS_DIV4:  conv_min = CONV_MIN_11;
      default:   conv_min = CONV_MIN_00;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      phase_reg <= '0;
    end else if (i_ce) begin
      phase_reg <= phase_next;
    end
  end

  // Tick once per division period; delay spans one to two periods
  assign o_phase_tick = ((phase_reg & phase_mask) == phase_mask);
  assign o_sample_len = adct_cnt_t'(SAMPLE_00 >> shift);
  // Conversion after sampling: minimum total less minimum delay and sampling
  assign o_body_len   = adct_cnt_t'(conv_min - (DELAY_MIN_00 >> shift) - (SAMPLE_00 >> shift));
  assign o_scan_len   = adct_cnt_t'(SCAN_CONV_00 >> shift);

endmodule

// >>> hw/adct_conv_ctrl.sv
// Converter timing, trigger, end-flag and standby control
// Notes on behaviour
// - After start flag sets, wait start delay, sample input, then approximate.
// - Start delay 31-62, 15-30, 7-14 or 3-6 states per clock select.
// - Sampling lasts 256, 128, 64 or 32 states per clock select.
// - Single conversion totals 1024-1055, 515-530, 259-266 or 131-134 states.
// - First scan conversion follows single-mode delay and total time.
// - Later scan conversions take exactly 1024, 512, 256 or 128 states.
// - Enabled timer request sets start flag automatically, per converter unit.
// - Hardware-set start flag times the same as a software write.
// - External pin honoured only with trigger select 00 or 01.
// - Falling edge of active-low pin sets start flag, then acts as software start.
// - End interrupt requested while end flag set and enable bit one.
// - When routed to transfer controller, no processor interrupt is delivered.
// - Transfer controller's data transfer clears the end flag automatically.
// - After reset the converter stays halted in module standby.
// - Control bits accessible only once module standby is cleared.
// - Select 00 pin or timer, 01 pin, 10 timer, 11 motor timer.
// - Single mode start flag holds during conversion, clears at end; early clear aborts.
module adct_conv_ctrl
  import adct_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_module_standby,
  input  wire adct_ctrl_s  i_ctrl,
  input  wire logic        i_ctrl_write,
  input  wire logic        i_start_write,
  input  wire logic        i_start_write_value,
  input  wire adct_trig_s  i_trig,
  input  wire logic        i_end_flag_clear,
  input  wire logic        i_transfer_done,
  input  wire logic [RES_W-1:0] i_sar_result,
  output logic             o_conversion_start_flag,
  output logic             o_conversion_end_flag,
  output logic             o_conversion_end_irq,
  output logic             o_transfer_request,
  output logic             o_sample_hold,
  output logic             o_sar_active,
  output logic             o_result_valid,
  output logic [1:0]       o_channel,
  output logic [RES_W-1:0] o_result,
  output logic             o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELAY,
    ST_SAMPLE,
    ST_CONVERT
  } adct_state_e;

  adct_state_e      state_reg, state_next;
  adct_ctrl_s       ctrl_reg, ctrl_next;
  adct_cnt_t        cnt_reg, cnt_next;
  logic             start_reg, start_next;
  logic             end_reg, end_next;
  logic             first_reg, first_next;
  logic [1:0]       chan_reg, chan_next;
  logic             trig_n_reg, trig_n_next;
  logic [RES_W-1:0] result_reg, result_next;
  logic             valid_reg, valid_next;
  logic             delay_ticked_reg, delay_ticked_next;

  logic             phase_tick;
  adct_cnt_t        sample_len, body_len, scan_len;
  adct_cnt_t        delay_len;
  logic             pin_enabled, pin_fall, timer_hit, hw_start;
  logic             active;

  adct_phase_gen u_phase (
    .i_ref_clk      (i_ref_clk),
    .i_rstn         (i_rstn),
    .i_ce           (i_ce),
    .i_clock_select (ctrl_reg.clock_select),
    .o_phase_tick   (phase_tick),
    .o_sample_len   (sample_len),
    .o_body_len     (body_len),
    .o_scan_len     (scan_len)
  );

  // Fixed part of the start delay after the synchronising tick
  assign delay_len = adct_cnt_t'((DELAY_MIN_00 >> ctrl_reg.clock_select) - DELAY_SYNC);

  // Standby halts all but the phase counter and blocks control access
  assign active = i_ce && !i_module_standby;

  always_comb begin
    pin_enabled = (ctrl_reg.trigger_source_select == TRG_PIN_OR_MFT) ||
                  (ctrl_reg.trigger_source_select == TRG_PIN_ONLY);
    pin_fall    = pin_enabled && trig_n_reg && !i_trig.ext_trigger_n;
    case (ctrl_reg.trigger_source_select)
      TRG_PIN_OR_MFT: timer_hit = |i_trig.mft_req;
      TRG_PIN_ONLY:   timer_hit = 1'b0;
      TRG_MFT_ONLY:   timer_hit = |i_trig.mft_req;
      TRG_MOTOR_ONLY: timer_hit = i_trig.motor_req;
      default:        timer_hit = 1'b0;
    endcase
    hw_start = timer_hit || pin_fall;
  end

  always_comb begin
    state_next        = state_reg;
    ctrl_next         = ctrl_reg;
    cnt_next          = cnt_reg;
    start_next        = start_reg;
    end_next          = end_reg;
    first_next        = first_reg;
    chan_next         = chan_reg;
    trig_n_next       = i_trig.ext_trigger_n;
    result_next       = result_reg;
    valid_next        = 1'b0;
    delay_ticked_next = delay_ticked_reg;

    if (i_ctrl_write) begin
      ctrl_next = i_ctrl;
    end
    if (i_start_write) begin
      start_next = i_start_write_value;
    end
    if (hw_start) begin
      start_next = 1'b1;
    end

    case (state_reg)
      ST_IDLE: begin
        if (start_reg) begin
          state_next        = ST_DELAY;
          first_next        = 1'b1;
          chan_next         = 2'h0;
          delay_ticked_next = 1'b0;
        end
      end
      ST_DELAY: begin
        // First division tick synchronises, then a fixed count
        if (delay_ticked_reg) begin
          if (cnt_reg == '0) begin
            state_next = ST_SAMPLE;
            cnt_next   = sample_len - adct_cnt_t'(1);
          end else begin
            cnt_next = cnt_reg - adct_cnt_t'(1);
          end
        end else if (phase_tick) begin
          delay_ticked_next = 1'b1;
          cnt_next          = delay_len - adct_cnt_t'(1);
        end
      end
      ST_SAMPLE: begin
        if (cnt_reg == '0) begin
          state_next = ST_CONVERT;
          cnt_next   = body_len - adct_cnt_t'(1);
        end else begin
          cnt_next = cnt_reg - adct_cnt_t'(1);
        end
      end
      ST_CONVERT: begin
        if (cnt_reg == '0) begin
          result_next = i_sar_result;
          valid_next  = 1'b1;
          if (!ctrl_reg.scan_mode) begin
            end_next   = 1'b1;
            start_next = 1'b0;
            state_next = ST_IDLE;
          end else if (chan_reg == ctrl_reg.scan_count_m1) begin
            end_next = 1'b1;
            if (ctrl_reg.scan_continuous) begin
              chan_next  = 2'h0;
              state_next = ST_SAMPLE;
              cnt_next   = sample_len - adct_cnt_t'(1);
            end else begin
              start_next = 1'b0;
              state_next = ST_IDLE;
            end
          end else begin
            chan_next  = chan_reg + 2'h1;
            state_next = ST_SAMPLE;
            cnt_next   = sample_len - adct_cnt_t'(1);
          end
          first_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - adct_cnt_t'(1);
        end
        // Later scan conversions: sample plus body equals fixed length
        if (cnt_reg == '0 && ctrl_reg.scan_mode && state_next == ST_SAMPLE) begin
          cnt_next = sample_len - adct_cnt_t'(1);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase

    // Scan body after the first uses the fixed period
    if (state_reg == ST_SAMPLE && cnt_reg == '0 && !first_reg) begin
      cnt_next = scan_len - sample_len - adct_cnt_t'(1);
    end

    // Clearing start mid-conversion aborts
    if (!start_next && state_next != ST_IDLE && state_reg != ST_IDLE) begin
      state_next = ST_IDLE;
    end

    if (i_end_flag_clear) begin
      end_next = 1'b0;
    end
    if (ctrl_reg.route_to_transfer_controller && i_transfer_done) begin
      end_next = 1'b0;
    end
    // Completion wins over a clear in the same cycle
    if (state_reg == ST_CONVERT && cnt_reg == '0 &&
        (!ctrl_reg.scan_mode || chan_reg == ctrl_reg.scan_count_m1)) begin
      end_next = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_reg        <= ST_IDLE;
      ctrl_reg         <= '0;
      cnt_reg          <= '0;
      start_reg        <= 1'b0;
      end_reg          <= 1'b0;
      first_reg        <= 1'b0;
      chan_reg         <= 2'h0;
      trig_n_reg       <= 1'b1;
      result_reg       <= '0;
      valid_reg        <= 1'b0;
      delay_ticked_reg <= 1'b0;
    end else if (active) begin
      state_reg        <= state_next;
      ctrl_reg         <= ctrl_next;
      cnt_reg          <= cnt_next;
      start_reg        <= start_next;
      end_reg          <= end_next;
      first_reg        <= first_next;
      chan_reg         <= chan_next;
      trig_n_reg       <= trig_n_next;
      result_reg       <= result_next;
      valid_reg        <= valid_next;
      delay_ticked_reg <= delay_ticked_next;
    end
  end

  assign o_conversion_start_flag = start_reg;
  assign o_conversion_end_flag   = end_reg;
  assign o_conversion_end_irq    = end_reg && ctrl_reg.end_irq_enable &&
                                   !ctrl_reg.route_to_transfer_controller;
  assign o_transfer_request      = end_reg && ctrl_reg.end_irq_enable &&
                                   ctrl_reg.route_to_transfer_controller;
  assign o_sample_hold           = (state_reg == ST_SAMPLE);
  assign o_sar_active            = (state_reg == ST_CONVERT);
  assign o_result_valid          = valid_reg;
  assign o_channel               = chan_reg;
  assign o_result                = result_reg;
  assign o_busy                  = (state_reg != ST_IDLE);

endmodule

// >>> verif/adct_assertions.sv
// Checker of conversion timing, trigger and end-flag handling
module adct_chk
  import adct_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire logic       i_ce,
  input wire logic       i_module_standby,
  input wire adct_ctrl_s i_ctrl,
  input wire logic       i_ctrl_write,
  input wire logic       i_start_write,
  input wire adct_trig_s i_trig,
  input wire logic       i_transfer_done,
  input wire logic       o_conversion_start_flag,
  input wire logic       o_conversion_end_flag,
  input wire logic       o_conversion_end_irq,
  input wire logic       o_sample_hold,
  input wire logic       o_sar_active,
  input wire logic       o_result_valid,
  input wire logic       o_busy
);
  localparam int CLO [4] = '{1024, 515, 259, 131};
  localparam int CHI [4] = '{1055, 530, 266, 134};
  adct_ctrl_s ctl_reg;
  adct_cnt_t  tot_reg;
  adct_cnt_t  sh_reg;
  logic       seen_reg;
  logic       done_reg;
  logic [1:0] ck;
  logic [1:0] tg;
  logic       go;
  logic       quiet;
  assign ck = ctl_reg.clock_select;
  assign tg = ctl_reg.trigger_source_select;
  assign go = i_ce && !i_module_standby && !o_conversion_start_flag;
  assign quiet = !i_start_write && i_trig.mft_req == 2'h0 && !i_trig.motor_req;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Mirror of loaded control bits, states since start and since last result
  always_ff @(posedge i_ref_clk) begin
    sh_reg <= o_sample_hold ? sh_reg + 11'h001 : 11'h000;
    if (!i_rstn) begin
      ctl_reg <= '0;
    end else if (i_ctrl_write && i_ce && !i_module_standby) begin
      ctl_reg <= i_ctrl;
    end
    if (!i_rstn || !o_conversion_start_flag) begin
      tot_reg <= 11'h000;
      seen_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      tot_reg <= o_result_valid ? 11'h001 : tot_reg + 11'h001;
      seen_reg <= seen_reg | o_sample_hold;
      done_reg <= done_reg | o_result_valid;
    end
  end
  chk_start_delay: assert property ($rose(o_sample_hold) && !seen_reg
    |-> tot_reg >= (DELAY_MIN_00 >> ck) && tot_reg <= 2 * (DELAY_MIN_00 >> ck)) else $error("bad start delay");
  chk_sample_len: assert property ($fell(o_sample_hold)
    |-> o_sar_active && sh_reg == (SAMPLE_00 >> ck)) else $error("bad sampling length");
  chk_first_total: assert property (o_result_valid && !done_reg
    |-> tot_reg >= CLO[ck] && tot_reg <= CHI[ck]) else $error("bad first conversion time");
  chk_scan_period: assert property (o_result_valid && done_reg
    |-> tot_reg == (SCAN_CONV_00 >> ck)) else $error("bad scan conversion time");
  chk_pin_start: assert property ($fell(i_trig.ext_trigger_n) && !tg[1] && go
    |-> ##[1:2] o_conversion_start_flag) else $error("pin edge did not start");
  chk_pin_ignored: assert property ($fell(i_trig.ext_trigger_n) && tg[1] && go && quiet
    |=> !o_conversion_start_flag) else $error("disabled pin started");
  chk_timer_start: assert property (go && (i_trig.motor_req && tg == 2'h3 || i_trig.mft_req != 2'h0 && !tg[0])
    |-> ##[1:2] o_conversion_start_flag) else $error("timer request did not start");
  chk_irq_gate: assert property (o_conversion_end_irq ==
    (o_conversion_end_flag && ctl_reg.end_irq_enable && !ctl_reg.route_to_transfer_controller)) else $error("bad irq");
  chk_auto_clear: assert property (i_transfer_done && ctl_reg.route_to_transfer_controller && !o_busy && go
    |=> !o_conversion_end_flag) else $error("end flag not cleared");
  cover property (o_result_valid && done_reg);
  cover property ($fell(i_trig.ext_trigger_n) && go);
  cover property (i_transfer_done && o_conversion_end_flag);
endmodule

// >>> verif/adct_far_model.sv
// Model of timers, trigger pin and transfer controller
module adct_far_model
  import adct_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_slow,
  input  wire logic i_transfer_request,
  output adct_trig_s o_trig,
  output logic       o_transfer_done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_trig = 4'h1;
    o_transfer_done = 1'h0;
  end
  // One-cycle timer request or low pin pulse
  task automatic fire(input logic [3:0] v);
    @(posedge i_ref_clk);
    #1 o_trig = v;
    @(posedge i_ref_clk);
    #1 o_trig = 4'h1;
  endtask
  // Waits zero or five cycles, then reports the transfer
  always @(posedge i_ref_clk) begin
    if (i_transfer_request) begin
      repeat (i_slow ? 5 : 0) @(posedge i_ref_clk);
      #1 o_transfer_done = 1'h1;
      @(posedge i_ref_clk);
      #1 o_transfer_done = 1'h0;
    end
  end
endmodule

// >>> verif/tb.sv
// Testbench of conversion timing and trigger control
module tb
  import adct_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LO [4] = '{1024, 515, 259, 131};
  localparam int HI [4] = '{1055, 530, 266, 134};
  logic             i_ref_clk = 1'h0;
  logic             i_rstn = 1'h0;
  logic             i_ce = 1'h1;
  logic             i_module_standby = 1'h1;
  adct_ctrl_s       i_ctrl = '0;
  logic             i_ctrl_write = 1'h0;
  logic             i_start_write = 1'h0;
  logic             i_start_write_value = 1'h0;
  logic             i_end_flag_clear = 1'h0;
  logic [RES_W-1:0] i_sar_result = 10'h2A5;
  logic             slow = 1'h0;
  logic             cont = 1'h0;
  adct_trig_s       i_trig;
  logic             i_transfer_done, o_conversion_start_flag, o_conversion_end_flag, o_conversion_end_irq;
  logic             o_transfer_request, o_sample_hold, o_sar_active, o_result_valid, o_busy;
  logic [1:0]       o_channel;
  logic [RES_W-1:0] o_result;
  int               err_total = 0;
  int               checks_done = 0;
  int               n;
  adct_conv_ctrl adct_conv_ctrl_inst (
    .i_ref_clk, .i_rstn, .i_ce, .i_module_standby, .i_ctrl, .i_ctrl_write, .i_start_write,
    .i_start_write_value, .i_trig, .i_end_flag_clear, .i_transfer_done, .i_sar_result,
    .o_conversion_start_flag, .o_conversion_end_flag, .o_conversion_end_irq, .o_transfer_request,
    .o_sample_hold, .o_sar_active, .o_result_valid, .o_channel, .o_result, .o_busy
  );
  adct_far_model adct_far_model_inst (
    .i_ref_clk, .i_slow(slow), .i_transfer_request(o_transfer_request),
    .o_trig(i_trig), .o_transfer_done(i_transfer_done)
  );
  always #50 i_ref_clk = ~i_ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic sm, input logic [1:0] ck, tg, input logic ie, rt);
    i_ctrl = '{sm, cont, 2'h1, ck, tg, ie, rt};
    i_ctrl_write = 1'h1;
    tick(1);
    i_ctrl_write = 1'h0;
  endtask
  task automatic start(input logic v);
    i_start_write = 1'h1;
    i_start_write_value = v;
    tick(1);
    i_start_write = 1'h0;
  endtask
  task automatic clr;
    i_end_flag_clear = 1'h1;
    tick(1);
    i_end_flag_clear = 1'h0;
  endtask
  // Bounded wait for a level; n holds the cycles waited
  task automatic wait_for(ref logic s, input logic v);
    for (n = 0; n < 3000 && s !== v; n++) tick(1);
    check(s, v);
  endtask
  task automatic t_standby;
    start(1'h1);
    tick(2);
    check(o_conversion_start_flag, 1'h0);
    i_module_standby = 1'h0;
    tick(1);
    $display("standby test done");
  endtask
  task automatic t_single;
    for (int k = 0; k < 4; k++) begin
      i_sar_result = {k[1:0], 8'h5A};
      wr(1'h0, k[1:0], 2'h1, 1'h1, 1'h0);
      start(1'h1);
      wait_for(o_conversion_start_flag, 1'h1);
      wait_for(o_conversion_start_flag, 1'h0);
      check(n >= LO[k] && n <= HI[k], 1'h1);
      check({o_conversion_end_flag, o_conversion_end_irq, o_busy}, 3'h6);
      check(o_result, {k[1:0], 8'h5A});
      clr;
      check(o_conversion_end_irq, 1'h0);
    end
    $display("single test done");
  endtask
  task automatic t_scan;
    for (int s = 1; s >= 0; s--) begin
      cont = s[0];
      wr(1'h1, 2'h3, 2'h1, 1'h0, 1'h0);
      start(1'h1);
      wait_for(o_result_valid, 1'h1);
      check(n >= LO[3] && n <= HI[3], 1'h1);
      check(o_channel, 2'h1);
      tick(1);
      wait_for(o_result_valid, 1'h1);
      check(n + 1, 128);
      if (cont) begin
        // Continuous run stops only by clearing the start flag
        wait_for(o_sar_active, 1'h1);
        start(1'h0);
        check(o_busy, 1'h0);
      end else begin
        wait_for(o_conversion_start_flag, 1'h0);
      end
      check(o_conversion_end_flag, 1'h1);
      clr;
    end
    $display("scan test done");
  endtask
  task automatic t_trig;
    logic [3:0] ev [3] = '{4'h0, 4'h9, 4'h3};
    logic [3:0] ok [3] = '{4'h3, 4'h5, 4'h8};
    for (int t = 0; t < 4; t++) begin
      for (int e = 0; e < 3; e++) begin
        wr(1'h0, 2'h0, t[1:0], 1'h0, 1'h0);
        adct_far_model_inst.fire(ev[e]);
        tick(2);
        check(o_conversion_start_flag, ok[e][t]);
        start(1'h0);
        tick(2);
        check(o_busy, 1'h0);
      end
    end
    $display("trigger test done");
  endtask
  task automatic t_dtc;
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      wr(1'h0, 2'h3, 2'h1, 1'h1, 1'h1);
      adct_far_model_inst.fire(4'h0);
      wait_for(o_conversion_end_flag, 1'h1);
      check({o_conversion_end_irq, o_transfer_request}, 2'h1);
      wait_for(o_conversion_end_flag, 1'h0);
    end
    wr(1'h0, 2'h3, 2'h1, 1'h0, 1'h0);
    start(1'h1);
    wait_for(o_conversion_end_flag, 1'h1);
    check(o_conversion_end_irq, 1'h0);
    clr;
    $display("transfer test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(20);
    i_rstn = 1'h1;
    t_standby;
    t_single;
    t_scan;
    t_trig;
    t_dtc;
    finish_test;
  end
  // About six times the expected run of some 3200 cycles
  initial begin
    #2000000;
    err_total++;
    $display("watchdog expired");
    finish_test;
  end
endmodule
bind adct_conv_ctrl adct_chk adct_chk_inst (
  .i_ref_clk, .i_rstn, .i_ce, .i_module_standby, .i_ctrl, .i_ctrl_write, .i_start_write, .i_trig,
  .i_transfer_done, .o_conversion_start_flag, .o_conversion_end_flag, .o_conversion_end_irq,
  .o_sample_hold, .o_sar_active, .o_result_valid, .o_busy
);
